// [design/spm_pkg.sv]
// Purpose: constants, types and helpers for the flash self-programming controller
// Assumes: 100 MHz core clock, byte-addressed 16-bit pointer, 64-word pages
// Notes: every register offset, the control bit positions and the page, lock and timing counts live here
//
// What this block does
// - reset vector follows boot reset select fuse
// - processor can never alter any fuse
// - pointer low bits word, high bits page
// - target page latched when operation starts
// - lock-bit setting ignores the address pointer
// - program reads select byte by pointer bit0
// - erase pattern then store within four cycles
// - halt core for no-read-while-write targets
// - load pattern stores data pair into buffer
// - buffer cleared after write, reenable, reset
// - eeprom write during loading discards buffer
// - write pattern programs buffer into page
// - interrupt asserted while enabled and idle
// - erase/write block area, busy until reenable
// - lock programming clears bits where data zero
// - lock programming never halts or blocks reads
// - eeprom busy rejects commands and fuse reads
// - command bits auto-clear after four idle cycles
// - erase, write, lock take 3.7-4.5 ms
// - programmed fuse/lock bits read as zero
`default_nettype none
package spm_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_STORE = 8'h0c;
	localparam logic [7:0] OFF_LOAD = 8'h10;
	localparam logic [7:0] OFF_LOCK = 8'h14;
	localparam logic [7:0] OFF_FUSE = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	// control/status register bit positions
	localparam int CB_EN = 0;
	localparam int CB_BUSY = 6;
	localparam int CB_IE = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	// pointer split: bit0 byte, 6 word bits, 9 page bits
	localparam int WORD_LSB = 1;
	localparam int WORD_BITS = 6;
	localparam int PAGE_LSB = 7;
	localparam int PAGE_BITS = 9;
	localparam int PAGE_WORDS = 64;
	localparam int LOCK_BITS = 6;
	localparam logic [15:0] APP_RESET_VEC = 16'h0000;
	// timed sequence window and programming time
	localparam logic [2:0] WINDOW_CYCLES = 3'd4;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_MIN_NS = 3700000;
	localparam int PROG_TIME_MAX_NS = 4500000;
	localparam int PROG_CYCLES_DEF = (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_BITS = 20;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_BUSY = 2'b10
	} state_t;

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_LOAD = 3'b001,
		CMD_ERASE = 3'b010,
		CMD_WRITE = 3'b011,
		CMD_LOCK = 3'b100,
		CMD_REEN = 3'b101
	} cmd_t;

	// bits 7 and 6 are don't-care except for the load pattern, which is exact
	function automatic cmd_t decode_cmd(input logic [7:0] c);
		cmd_t r;
		r = CMD_NONE;
		if (c == 8'h01) r = CMD_LOAD;
		else if (c[5:0] == 6'h03) r = CMD_ERASE;
		else if (c[5:0] == 6'h05) r = CMD_WRITE;
		else if (c[5:0] == 6'h09) r = CMD_LOCK;
		else if (c[5:0] == 6'h11) r = CMD_REEN;
		return r;
	endfunction : decode_cmd

	function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] z);
		return z[PAGE_LSB +: PAGE_BITS];
	endfunction : page_of

	function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] z);
		return z[WORD_LSB +: WORD_BITS];
	endfunction : word_of
endpackage : spm_pkg
`default_nettype wire

// [design/page_buf_if.sv]
// Purpose: bundle between sequencer and temporary page buffer
// Assumes: one clock domain
// Notes: rd side is the flash programmer's fetch port
`default_nettype none
interface page_buf_if;
	logic wr_en;
	logic [5:0] wr_idx;
	logic [15:0] wr_data;
	logic clear;
	logic dirty;
	logic [5:0] rd_idx;
	logic [15:0] rd_data;
	modport ctrl (output wr_en, wr_idx, wr_data, clear, rd_idx, input dirty, rd_data);
	modport store (input wr_en, wr_idx, wr_data, clear, rd_idx, output dirty, rd_data);
endinterface : page_buf_if
`default_nettype wire

// [design/page_buffer.sv]
// Purpose: temporary page buffer, one 16-bit word per page slot
// Assumes: clear and write never meaningful in the same cycle; clear wins
// Notes: cleared words read as erased flash
`default_nettype none
module page_buffer
	import spm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_sync_n,
	page_buf_if.store pb
);
	logic [15:0] mem [PAGE_WORDS];

	// whole-buffer clear beats a load so discarded data never survives
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			for (int i = 0; i < PAGE_WORDS; i++) mem[i] <= ERASED_WORD;
		end else if (pb.clear) begin
			for (int i = 0; i < PAGE_WORDS; i++) mem[i] <= ERASED_WORD;
		end else if (pb.wr_en) begin
			mem[pb.wr_idx] <= pb.wr_data;
		end
	end

	// any word loaded since the last clear
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) pb.dirty <= 1'b0;
		else if (pb.clear) pb.dirty <= 1'b0;
		else if (pb.wr_en) pb.dirty <= 1'b1;
	end

	// registered fetch port for the flash programmer
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) pb.rd_data <= ERASED_WORD;
		else pb.rd_data <= mem[pb.rd_idx];
	end
endmodule : page_buffer
`default_nettype wire

// [design/prog_timer.sv]
// Purpose: times one erase, write or lock-programming operation
// Assumes: start is a one-cycle pulse while idle
// Notes: done pulses on the last cycle of the run
`default_nettype none
module prog_timer
	import spm_pkg::*;
#(
	parameter int CYCLES = PROG_CYCLES_DEF
) (
	input wire logic core_clk,
	input wire logic rst_sync_n,
	input wire logic start,
	output logic busy,
	output logic done
);
	localparam logic [TIMER_BITS-1:0] LOAD_VAL = TIMER_BITS'(CYCLES - 1);
	logic [TIMER_BITS-1:0] count;

	// counts down from the programming time; restart ignored while running
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			count <= '0;
			busy <= 1'b0;
		end else if (start && !busy) begin
			count <= LOAD_VAL;
			busy <= 1'b1;
		end else if (busy) begin
			count <= count - 1'b1;
			if (count == '0) busy <= 1'b0;
		end
	end

	assign done = busy && (count == '0);
endmodule : prog_timer
`default_nettype wire

// [design/flash_self_programming_ctrl.sv]
// Purpose: self-programming sequencer with APB register access
// Assumes: flash array and nonvolatile cells sit outside and follow the pulses
// Notes: one wait state on every APB access
//
// Our own choices: the APB interface to the registers and the register offsets.
`default_nettype none
module flash_self_programming_ctrl
	import spm_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF,
	parameter logic [15:0] BOOT_RESET_VEC = 16'h7000,
	parameter logic [PAGE_BITS-1:0] NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = 9'h1c0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic boot_reset_select_fuse,
	input wire logic eeprom_write_busy_bit,
	input wire logic [LOCK_BITS-1:0] lock_bits_in,
	input wire logic [15:0] flash_rword,
	output logic [14:0] flash_raddr,
	output logic [15:0] reset_vector,
	output logic spm_irq,
	output logic cpu_halt,
	output logic rww_read_block,
	output logic flash_erase_start,
	output logic flash_write_start,
	output logic lock_program_start,
	output logic [LOCK_BITS-1:0] lock_program_mask,
	output logic [PAGE_BITS-1:0] flash_page,
	input wire logic [WORD_BITS-1:0] flash_buf_idx,
	output logic [15:0] flash_buf_word
);
	logic rst_meta_n;
	logic rst_sync_n;
	logic fuse_q;
	logic fuse_taken;
	logic ack;
	logic wr_fire;
	logic rd_take;
	logic store_fire;
	logic ctrl_wr;
	logic [15:0] addr_ptr;
	logic [15:0] data_pair;
	logic [7:0] cmd_bits;
	logic ie;
	logic rww_busy;
	logic [2:0] window;
	state_t state;
	cmd_t cmd;
	cmd_t op;
	logic timer_start;
	logic timer_busy;
	logic timer_done;
	logic [31:0] next_rdata;
	logic next_err;
	logic fuse_read_ok;

	page_buf_if pb ();

	// reset: async assert, release through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// fuse is a strap: sampled once after release, never written
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fuse_q <= 1'b1;
			fuse_taken <= 1'b0;
		end else if (!fuse_taken) begin
			fuse_q <= boot_reset_select_fuse;
			fuse_taken <= 1'b1;
		end
	end
	assign reset_vector = fuse_q ? APP_RESET_VEC : BOOT_RESET_VEC;

	// apb: first access cycle samples, second answers
	assign wr_fire = psel && penable && ack && pwrite;
	assign rd_take = psel && penable && !ack;
	assign pready = ack;
	assign store_fire = wr_fire && (paddr == OFF_STORE);
	assign ctrl_wr = wr_fire && (paddr == OFF_CTRL);
	assign cmd = decode_cmd(cmd_bits);

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) ack <= 1'b0;
		else ack <= rd_take;
	end

	// pointer and data pair stay free for software once an op has latched its page
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			addr_ptr <= ADDR_RESET;
			data_pair <= DATA_RESET;
		end else if (wr_fire && paddr == OFF_ADDR) begin
			addr_ptr <= pwdata[15:0];
		end else if (wr_fire && paddr == OFF_DATA) begin
			data_pair <= pwdata[15:0];
		end
	end
	assign flash_raddr = addr_ptr[15:1];

	// sequencer: arm on control write, act on the store strobe, time the op
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ST_IDLE;
			cmd_bits <= CTRL_RESET;
			window <= '0;
			op <= CMD_NONE;
		end else begin
			case (state)
				ST_IDLE: begin
					// eeprom write in progress locks out the whole control register
					if (ctrl_wr && !eeprom_write_busy_bit && pwdata[CB_EN]) begin
						cmd_bits <= pwdata[7:0];
						window <= WINDOW_CYCLES;
						state <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (store_fire && !eeprom_write_busy_bit) begin
						case (cmd)
							CMD_ERASE, CMD_WRITE, CMD_LOCK: begin
								op <= cmd;
								state <= ST_BUSY;
							end
							default: begin
								cmd_bits <= CTRL_RESET;
								state <= ST_IDLE;
							end
						endcase
					end else if (window == 3'd1 || store_fire) begin
						cmd_bits <= CTRL_RESET;
						state <= ST_IDLE;
					end
					if (window != '0) window <= window - 1'b1;
				end
				ST_BUSY: begin
					// control writes stay ignored until the enable bit drops
					if (timer_done) begin
						cmd_bits <= CTRL_RESET;
						op <= CMD_NONE;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// interrupt enable may be changed only while nothing is armed
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) ie <= 1'b0;
		else if (ctrl_wr && state == ST_IDLE && !eeprom_write_busy_bit) ie <= pwdata[CB_IE];
	end

	// op start: latch page from the pointer, lock op never looks at it
	assign timer_start = (state == ST_ARMED) && store_fire && !eeprom_write_busy_bit
		&& (cmd == CMD_ERASE || cmd == CMD_WRITE || cmd == CMD_LOCK);

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flash_page <= '0;
			lock_program_mask <= '0;
			flash_erase_start <= 1'b0;
			flash_write_start <= 1'b0;
			lock_program_start <= 1'b0;
		end else begin
			flash_erase_start <= timer_start && cmd == CMD_ERASE;
			flash_write_start <= timer_start && cmd == CMD_WRITE;
			lock_program_start <= timer_start && cmd == CMD_LOCK;
			if (timer_start && cmd != CMD_LOCK) flash_page <= page_of(addr_ptr);
			if (timer_start && cmd == CMD_LOCK) lock_program_mask <= ~data_pair[5:0];
		end
	end

	prog_timer #(
		.CYCLES(PROG_CYCLES)
	) u_timer (
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.start(timer_start),
		.busy(timer_busy),
		.done(timer_done)
	);

	// area busy flag: set by erase/write, cleared only by re-enable after completion
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) rww_busy <= 1'b0;
		else if (timer_start && cmd != CMD_LOCK) rww_busy <= 1'b1;
		else if (state == ST_ARMED && store_fire && cmd == CMD_REEN && !eeprom_write_busy_bit)
			rww_busy <= 1'b0;
	end

	// lock programming leaves both areas readable and the core running
	assign rww_read_block = (state == ST_BUSY) && (op != CMD_LOCK);
	assign cpu_halt = rww_read_block && (flash_page >= NO_READ_WHILE_WRITE_AREA_FIRST_PAGE);
	assign spm_irq = ie && (state == ST_IDLE);

	// temporary buffer: load, and the three ways it is wiped
	assign pb.wr_en = (state == ST_ARMED) && store_fire && cmd == CMD_LOAD
		&& !eeprom_write_busy_bit;
	assign pb.wr_idx = word_of(addr_ptr);
	assign pb.wr_data = data_pair;
	assign pb.clear = (timer_done && op == CMD_WRITE)
		|| ((state == ST_ARMED) && store_fire && cmd == CMD_REEN
		&& !eeprom_write_busy_bit)
		|| (eeprom_write_busy_bit && pb.dirty);
	assign pb.rd_idx = flash_buf_idx;
	assign flash_buf_word = pb.rd_data;

	page_buffer u_buf (
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.pb(pb)
	);

	// read mux; fuse and lock reads are refused during an eeprom write
	assign fuse_read_ok = !eeprom_write_busy_bit;
	always_comb begin
		next_rdata = '0;
		next_err = 1'b0;
		case (paddr)
			OFF_CTRL: next_rdata = {24'h0, ie, rww_busy, 1'b0, cmd_bits[4:1], state != ST_IDLE};
			OFF_ADDR: next_rdata = {16'h0, addr_ptr};
			OFF_DATA: next_rdata = {16'h0, data_pair};
			OFF_STORE: next_rdata = '0;
			OFF_LOAD: next_rdata = {24'h0, addr_ptr[0] ? flash_rword[15:8] : flash_rword[7:0]};
			OFF_LOCK: begin
				if (fuse_read_ok) next_rdata = {24'h0, 2'b11, lock_bits_in};
				else next_err = 1'b1;
			end
			OFF_FUSE: begin
				if (fuse_read_ok) next_rdata = {31'h0, fuse_q};
				else next_err = 1'b1;
			end
			OFF_STATUS: next_rdata = {28'h0, eeprom_write_busy_bit, cpu_halt,
				rww_read_block, pb.dirty};
			default: next_err = 1'b1;
		endcase
	end

	// answer registered in the first access cycle; writes to unmapped space also error
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (rd_take) begin
			prdata <= pwrite ? 32'h0 : next_rdata;
			pslverr <= pwrite ? (paddr > OFF_FUSE && paddr != OFF_STATUS) || paddr[1:0] != 2'b00
				: next_err;
		end else begin
			pslverr <= 1'b0;
		end
	end

	sequence s_armed_quiet;
		$rose(state == ST_ARMED) ##0 (state == ST_ARMED && !store_fire) [*4];
	endsequence

	a_window_expiry: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		s_armed_quiet |=> state == ST_IDLE && cmd_bits == CTRL_RESET)
		else $error("armed command did not auto-clear after four cycles");

	a_eeprom_reject: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		state == ST_IDLE && ctrl_wr && eeprom_write_busy_bit |=> state == ST_IDLE)
		else $error("command accepted during eeprom write");

	a_busy_flag_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		rww_busy && state != ST_ARMED |=> rww_busy)
		else $error("busy flag dropped without re-enable");

	a_page_stable: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		state == ST_BUSY && $past(state == ST_BUSY) |-> $stable(flash_page))
		else $error("latched page changed during operation");

	a_lock_no_halt: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		state == ST_BUSY && op == CMD_LOCK |-> !cpu_halt && !rww_read_block)
		else $error("lock programming blocked reads");

	a_erase_starts: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		flash_erase_start |-> state == ST_BUSY && op == CMD_ERASE && rww_busy)
		else $error("erase pulse without busy erase op");

	a_load_write: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		pb.wr_en |=> state == ST_IDLE && pb.dirty)
		else $error("buffer load did not complete in one cycle");

	a_write_clears: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		timer_done && op == CMD_WRITE |=> !pb.dirty && state == ST_IDLE)
		else $error("buffer not cleared after page write");

	a_irq_idle: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		ie && timer_done |=> spm_irq)
		else $error("interrupt missing after completion");

	a_halt_no_read_while_write_area: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		cpu_halt |-> rww_busy && op != CMD_LOCK)
		else $error("core halted outside erase or write");
endmodule : flash_self_programming_ctrl
`default_nettype wire

// [dv/flash_model.sv]
// Purpose: flash array and lock cell model on the far side of the sequencer
// Assumes: combinational array read, buffer fetched one word per cycle
// Notes: mem mirrors the temporary buffer about 66 cycles late
`default_nettype none
module flash_model
	import spm_pkg::*;
(
	input wire logic core_clk,
	input wire logic [14:0] flash_raddr,
	output logic [15:0] flash_rword,
	output logic [WORD_BITS-1:0] flash_buf_idx,
	input wire logic [15:0] flash_buf_word,
	input wire logic flash_erase_start,
	input wire logic flash_write_start,
	input wire logic lock_program_start,
	input wire logic [LOCK_BITS-1:0] lock_program_mask,
	output logic [LOCK_BITS-1:0] lock_bits_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_BITS-1:0] idx_d = 6'h00;
	logic [15:0] mem [PAGE_WORDS];
	int n_erase = 0;
	int n_write = 0;
	initial flash_buf_idx = 6'h00;
	// lock cells are nonvolatile: untouched by reset, all unprogrammed at start
	initial lock_bits_in = 6'h3f;
	// array word carries its own address so byte selection shows
	assign flash_rword = {flash_raddr[7:0], ~flash_raddr[7:0]};
	// word appears one cycle after its index, so capture under the delayed index
	always @(posedge core_clk) begin
		flash_buf_idx <= flash_buf_idx + 6'h01;
		idx_d <= flash_buf_idx;
		mem[idx_d] <= flash_buf_word;
	end
	// a programmed lock bit only ever goes to zero
	always @(posedge core_clk) begin
		if (lock_program_start) lock_bits_in <= lock_bits_in & ~lock_program_mask;
		if (flash_erase_start) n_erase <= n_erase + 1;
		if (flash_write_start) n_write <= n_write + 1;
	end
endmodule : flash_model
`default_nettype wire

// [dv/tb_flash_self_programming_ctrl.sv]
// Purpose: self-checking bench for the self-programming sequencer
// Assumes: programming time shortened to PC cycles
// Notes: apb leaves the bus up between command and store to keep the window
`default_nettype none
module tb_flash_self_programming_ctrl
	import spm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PC = 40;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, fuse = 1'b1, ee_busy = 1'b0;
	logic [5:0] lock_bits, mask, buf_idx;
	logic [15:0] rword, reset_vector, buf_word;
	logic [14:0] raddr;
	logic spm_irq, cpu_halt, rww_blk, ers, wrt, lck;
	logic [8:0] flash_page;
	logic [31:0] rdv;
	logic er;
	int n_errors = 0;
	int cmp_count = 0;

	flash_self_programming_ctrl #(.PROG_CYCLES(PC)) uut (.core_clk(core_clk), .rst_n(rst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_reset_select_fuse(fuse),
		.eeprom_write_busy_bit(ee_busy), .lock_bits_in(lock_bits), .flash_rword(rword),
		.flash_raddr(raddr), .reset_vector(reset_vector), .spm_irq(spm_irq),
		.cpu_halt(cpu_halt), .rww_read_block(rww_blk), .flash_erase_start(ers),
		.flash_write_start(wrt), .lock_program_start(lck), .lock_program_mask(mask),
		.flash_page(flash_page), .flash_buf_idx(buf_idx), .flash_buf_word(buf_word));
	flash_model fm (.core_clk(core_clk), .flash_raddr(raddr), .flash_rword(rword),
		.flash_buf_idx(buf_idx), .flash_buf_word(buf_word), .flash_erase_start(ers),
		.flash_write_start(wrt), .lock_program_start(lck), .lock_program_mask(mask),
		.lock_bits_in(lock_bits));

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one transfer; pready is read at the edge itself, before that edge's updates land
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input bit last);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("pready", 32'h1, 32'h0);
			print_verdict();
		end
		rdv = prdata;
		er = pslverr;
		if (last) begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge core_clk);
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b1);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0, 1'b1);
	endtask : rd

	// control write and store back to back keep the timed window atomic
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, OFF_CTRL, {24'h0, c}, 1'b0);
		apb(1'b1, OFF_STORE, 32'h0, 1'b1);
	endtask : cmd

	// the pulse stands in the last cycle of the store transfer, so look before waiting
	task automatic wait_pulse(input int k, output int n);
		n = 0;
		while (((k == 0) ? ers : (k == 1) ? wrt : lck) !== 1'b1 && n < 12) begin
			@(posedge core_clk);
			n++;
		end
		chk("start pulse", 32'h1, {31'h0, n < 12});
		if (n >= 12) print_verdict();
	endtask : wait_pulse

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			rd(OFF_CTRL);
			n++;
		end while (rdv[CB_EN] !== 1'b0 && n < 60);
		chk("idle", 32'h1, {31'h0, n < 60});
		if (n >= 60) print_verdict();
	endtask : wait_idle

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask : do_reset

	task automatic t_fuse();
		chk("vector app", 32'h0, {16'h0, reset_vector});
		wr(OFF_FUSE, 32'h0);
		rd(OFF_FUSE);
		chk("fuse after write", 32'h1, {31'h0, rdv[0]});
		fuse <= 1'b0;
		do_reset();
		chk("vector boot", 32'h7000, {16'h0, reset_vector});
		rd(OFF_FUSE);
		chk("fuse programmed", 32'h0, {31'h0, rdv[0]});
		fuse <= 1'b1;
		do_reset();
	endtask : t_fuse

	task automatic t_load();
		rd(OFF_STATUS);
		chk("eeprom busy", 32'h0, {31'h0, rdv[3]});
		wr(OFF_ADDR, 32'h0a4a);
		wr(OFF_DATA, 32'hbeef);
		cmd(8'h01);
		rd(OFF_STATUS);
		chk("dirty", 32'h1, {31'h0, rdv[0]});
		repeat (70) @(posedge core_clk);
		chk("buf word 37", 32'hbeef, {16'h0, fm.mem[37]});
		chk("buf word 36", 32'hffff, {16'h0, fm.mem[36]});
	endtask : t_load

	task automatic t_window();
		wr(OFF_ADDR, 32'h0010);
		wr(OFF_DATA, 32'h1234);
		wr(OFF_CTRL, 32'h01);
		repeat (6) @(posedge core_clk);
		rd(OFF_CTRL);
		chk("auto clear", 32'h0, {31'h0, rdv[CB_EN]});
		wr(OFF_STORE, 32'h0);
		repeat (70) @(posedge core_clk);
		chk("late store", 32'hffff, {16'h0, fm.mem[8]});
	endtask : t_window

	task automatic t_eeprom();
		ee_busy <= 1'b1;
		@(posedge core_clk);
		rd(OFF_STATUS);
		chk("dirty dropped", 32'h8, {28'h0, rdv[3:0]});
		rd(OFF_LOCK);
		chk("lock read refused", 32'h1, {31'h0, er});
		wr(OFF_ADDR, 32'h0000);
		wr(OFF_DATA, 32'h5555);
		cmd(8'h01);
		repeat (70) @(posedge core_clk);
		chk("refused load", 32'hffff, {16'h0, fm.mem[0]});
		chk("discarded", 32'hffff, {16'h0, fm.mem[37]});
		ee_busy <= 1'b0;
		@(posedge core_clk);
	endtask : t_eeprom

	task automatic t_erase();
		int n;
		wr(OFF_CTRL, 32'h80);
		chk("irq idle", 32'h1, {31'h0, spm_irq});
		wr(OFF_ADDR, 32'h0280);
		cmd(8'h83);
		wait_pulse(0, n);
		chk("erase page", 32'h5, {23'h0, flash_page});
		wr(OFF_ADDR, 32'hfffe);
		chk("page latched", 32'h5, {23'h0, flash_page});
		chk("rww blocked", 32'h1, {31'h0, rww_blk});
		chk("no halt rww", 32'h0, {31'h0, cpu_halt});
		chk("irq busy", 32'h0, {31'h0, spm_irq});
		rd(OFF_CTRL);
		chk("enable held", 32'h1, {31'h0, rdv[CB_EN]});
		cmd(8'h05);
		wait_idle();
		chk("write refused", 32'h0, fm.n_write);
		chk("one erase", 32'h1, fm.n_erase);
		rd(OFF_CTRL);
		chk("busy kept", 32'h1, {31'h0, rdv[CB_BUSY]});
		chk("irq done", 32'h1, {31'h0, spm_irq});
		wr(OFF_ADDR, 32'h0006);
		wr(OFF_DATA, 32'h0303);
		cmd(8'h01);
		cmd(8'h11);
		wait_idle();
		chk("busy cleared", 32'h0, {31'h0, rdv[CB_BUSY]});
		repeat (70) @(posedge core_clk);
		chk("reenable clears", 32'hffff, {16'h0, fm.mem[3]});
	endtask : t_erase

	task automatic t_write();
		int n;
		wr(OFF_ADDR, 32'he002);
		wr(OFF_DATA, 32'ha5a5);
		cmd(8'h01);
		wr(OFF_ADDR, 32'he000);
		cmd(8'h05);
		wait_pulse(1, n);
		chk("write page", 32'h1c0, {23'h0, flash_page});
		chk("halt no_read_while_write_area", 32'h1, {31'h0, cpu_halt});
		n = 0;
		while (cpu_halt === 1'b1 && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		chk("prog time", 32'h1, {31'h0, n >= PC - 2 && n <= PC + 1});
		if (n >= 200) print_verdict();
		wait_idle();
		repeat (70) @(posedge core_clk);
		chk("write clears", 32'hffff, {16'h0, fm.mem[1]});
		cmd(8'h11);
		wait_idle();
	endtask : t_write

	task automatic t_lock();
		int n;
		wr(OFF_ADDR, 32'h0001);
		wr(OFF_DATA, 32'h00c5);
		cmd(8'h09);
		wait_pulse(2, n);
		chk("lock mask", 32'h3a, {26'h0, mask});
		chk("lock no halt", 32'h0, {31'h0, cpu_halt});
		chk("lock readable", 32'h0, {31'h0, rww_blk});
		wait_idle();
		rd(OFF_LOCK);
		chk("lock readback", 32'hc5, rdv);
	endtask : t_lock

	task automatic t_lpm();
		wr(OFF_ADDR, 32'h0025);
		rd(OFF_LOAD);
		chk("high byte", 32'h12, rdv);
		wr(OFF_ADDR, 32'h0024);
		rd(OFF_LOAD);
		chk("low byte", 32'hed, rdv);
		rd(8'h20);
		chk("unmapped read", 32'h1, {31'h0, er});
		wr(OFF_STATUS, 32'h1);
		chk("status write", 32'h0, {31'h0, er});
		wr(8'h20, 32'h1);
		chk("unmapped write", 32'h1, {31'h0, er});
	endtask : t_lpm

	// main sequence; each scenario judges its own results
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_fuse();
		t_load();
		t_window();
		t_eeprom();
		t_erase();
		t_write();
		t_lock();
		t_lpm();
		print_verdict();
	end
endmodule : tb_flash_self_programming_ctrl
`default_nettype wire
